// ### hw/obc_config_decoder.sv
// Purpose: Load, decode and hold the two static option bytes, run reset and halt timing
// Assumes: Programming port usable only while the programming mode input is high
// Notes: Settings are sampled once after each reset and stay fixed until the next
//
// Operation
// (RL1) Halt with watchdog active resets if option set
// (RL2) Watchdog type: hardware always on or software
// (RL3) Clock source bit selects PLL or oscillator
// (RL4) Voltage field sets low and aux detector enables
// (RL5) Voltage code eleven meaning unconfirmed, erased default
// (RL6) Reset length bit: 4096 or 256 cycles
// (RL7) PLL clock forces 4096 cycle reset length
// (RL8) Programmer should choose long reset with resonators
// (RL9) Divide-by-two bit bypasses or halves the clock
// (RL10) Protection bit zero protects user flash
// (RL11) Protection blocks user memory in test, in-circuit
// (RL12) Option erase under protection erases user memory first
// (RL13) Erased option bytes read all ones
// (RL14) Option bytes absent from CPU map, programming only
// (RL15) Byte one bits set motor outputs during reset
// (RL16) Load bytes before reset release, hold until reset
`timescale 1ns/1ps

module obc_config_decoder (
	// Clock and resets
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_por_n,
	// Programming port
	input wire logic i_prog_mode,
	input wire logic [1:0] i_addr,
	input wire logic [7:0] i_wr_data,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rd_data,
	// Test and in-circuit access modes
	input wire logic i_test_mode,
	input wire logic i_in_circuit_programming_mode,
	// User memory erase handshake
	input wire logic i_user_erase_done,
	output logic o_user_erase_req,
	output logic o_user_mem_block,
	// CPU power state
	input wire logic i_wdog_sw_enabled,
	input wire logic i_halt_entry,
	input wire logic i_halt_wake,
	output logic o_cpu_reset_n,
	output logic o_halted,
	output logic o_wdog_halt_reset,
	// Decoded settings
	output obc_pkg::obc_settings_t o_settings,
	output logic o_watchdog_hw_enable,
	output logic o_pll_select,
	output logic o_prescaler_halve,
	// Motor control outputs under reset
	output logic o_motor_drive_level,
	output logic o_motor_drive_oe
);

	// ==========================================================
	// Functions
	function automatic obc_pkg::obc_settings_t decode_bytes(input logic [7:0] b0, input logic [7:0] b1);
		obc_pkg::obc_settings_t s;
		logic [1:0] vd;
		s = '0;
		vd = {b0[obc_pkg::BIT_VD_HI], b0[obc_pkg::BIT_VD_LO]};
		s.wdog_halt_reset_opt = b0[obc_pkg::BIT_WDOG_HALT]; // RL1
		s.wdog_software_opt = b0[obc_pkg::BIT_WDOG_SW]; // RL2
		s.clock_source_opt = b0[obc_pkg::BIT_CLK_SRC]; // RL3
		s.reset_length_opt = b0[obc_pkg::BIT_RST_LEN]; // RL6
		s.half_prescaler_opt = b0[obc_pkg::BIT_HALF_PRE]; // RL9
		s.readout_protect_opt = b0[obc_pkg::BIT_RDP]; // RL10
		s.motor_output_reset_state = {b1[obc_pkg::BIT_MOTOR_HI], b1[obc_pkg::BIT_MOTOR_LO]}; // RL15
		case (vd)
			obc_pkg::VD_BOTH_ON: begin
				s.low_voltage_detector = 1'b1; // RL4
				s.aux_voltage_detector = 1'b1;
			end
			obc_pkg::VD_LOW_ONLY: begin
				s.low_voltage_detector = 1'b1; // RL4
				s.aux_voltage_detector = 1'b0;
			end
			obc_pkg::VD_BOTH_OFF: begin
				s.low_voltage_detector = 1'b0; // RL4
				s.aux_voltage_detector = 1'b0;
			end
			default: begin
				// Erased code taken as both detectors on, pending confirmation
				s.low_voltage_detector = 1'b1; // RL5
				s.aux_voltage_detector = 1'b1; // RL5
			end
		endcase
		return s;
	endfunction

	function automatic logic [12:0] phase_cycles(input obc_pkg::obc_settings_t s);
		logic [12:0] n;
		n = obc_pkg::RESET_CYCLES_LONG;
		if (!s.clock_source_opt) begin
			n = obc_pkg::RESET_CYCLES_LONG; // RL7
		end else if (s.reset_length_opt) begin
			n = obc_pkg::RESET_CYCLES_SHORT; // RL6
		end
		return n;
	endfunction

	// ==========================================================
	// Declarations
	obc_pkg::obc_state_t state;
	obc_pkg::obc_state_t next_state;
	obc_pkg::obc_erase_t erase_state;
	obc_pkg::obc_settings_t next_settings;
	logic [12:0] count;
	logic [7:0] load_byte0;
	logic store_rd_sel;
	logic [7:0] store_rd_data;
	logic [7:0] live_byte0;
	logic [7:0] live_byte1;
	logic store_wr;
	logic store_erase;
	logic prog_wr;
	logic prog_rd;
	logic live_protect;
	logic wdog_active;
	logic count_done;

	// ==========================================================
	// Option store
	obc_option_store u_store (
		.i_clk(i_clk),
		.i_por_n(i_por_n),
		.i_wr(store_wr),
		.i_wr_sel(i_addr[0]),
		.i_wr_data(i_wr_data),
		.i_erase(store_erase),
		.i_rd_sel(store_rd_sel),
		.o_rd_data(store_rd_data),
		.o_byte0(live_byte0),
		.o_byte1(live_byte1)
	);

	// ==========================================================
	// Programming access qualification
	assign prog_wr = i_wr & i_prog_mode; // RL14
	assign prog_rd = i_rd & i_prog_mode; // RL14
	assign live_protect = ~live_byte0[obc_pkg::BIT_RDP];
	assign store_wr = prog_wr && (erase_state == obc_pkg::ER_IDLE) &&
		(i_addr == obc_pkg::OFS_OPT0 || i_addr == obc_pkg::OFS_OPT1);
	assign store_erase = (erase_state == obc_pkg::ER_OPTIONS);
	assign store_rd_sel = (state == obc_pkg::PH_LOAD1);
	assign wdog_active = ~o_settings.wdog_software_opt | i_wdog_sw_enabled;
	assign count_done = (count == 13'h0001);

	// ==========================================================
	// Option erase sequence
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			erase_state <= obc_pkg::ER_IDLE;
		end else begin
			case (erase_state)
				obc_pkg::ER_IDLE: begin
					if (prog_wr && i_addr == obc_pkg::OFS_ERASE) begin
						if (live_protect) begin
							erase_state <= obc_pkg::ER_USER_MEM; // RL12
						end else begin
							erase_state <= obc_pkg::ER_OPTIONS;
						end
					end
				end
				obc_pkg::ER_USER_MEM: begin
					if (i_user_erase_done) begin
						erase_state <= obc_pkg::ER_OPTIONS; // RL12
					end
				end
				default: begin
					erase_state <= obc_pkg::ER_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_user_erase_req <= 1'b0;
		end else begin
			o_user_erase_req <= (erase_state == obc_pkg::ER_USER_MEM) && !i_user_erase_done; // RL12
		end
	end

	// ==========================================================
	// User memory blocking in test and in-circuit modes
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_user_mem_block <= 1'b0;
		end else begin
			o_user_mem_block <= live_protect & (i_test_mode | i_in_circuit_programming_mode); // RL11
		end
	end

	// ==========================================================
	// Programming port read data
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rd_data <= obc_pkg::RD_DATA_RST;
		end else if (prog_rd) begin
			if (i_addr == obc_pkg::OFS_OPT0) begin
				o_rd_data <= live_byte0;
			end else if (i_addr == obc_pkg::OFS_OPT1) begin
				o_rd_data <= live_byte1;
			end else if (i_addr == obc_pkg::OFS_STATUS) begin
				o_rd_data <= {4'h0, live_protect, o_user_erase_req,
					erase_state != obc_pkg::ER_IDLE, state == obc_pkg::PH_RUN};
			end else begin
				o_rd_data <= obc_pkg::RD_DATA_RST;
			end
		end else begin
			o_rd_data <= obc_pkg::RD_DATA_RST;
		end
	end

	// ==========================================================
	// Load and power state sequence
	always_comb begin
		next_state = state;
		case (state)
			obc_pkg::PH_LOAD0: begin
				next_state = obc_pkg::PH_LOAD1;
			end
			obc_pkg::PH_LOAD1: begin
				next_state = obc_pkg::PH_LOAD2;
			end
			obc_pkg::PH_LOAD2: begin
				next_state = obc_pkg::PH_RESET_PHASE;
			end
			obc_pkg::PH_RESET_PHASE: begin
				if (count_done) begin
					next_state = obc_pkg::PH_RUN;
				end
			end
			obc_pkg::PH_RUN: begin
				if (i_halt_entry) begin
					if (wdog_active && o_settings.wdog_halt_reset_opt) begin
						next_state = obc_pkg::PH_RESET_PHASE; // RL1
					end else begin
						next_state = obc_pkg::PH_HALT; // RL1
					end
				end
			end
			obc_pkg::PH_HALT: begin
				if (i_halt_wake) begin
					next_state = obc_pkg::PH_HALT_EXIT;
				end
			end
			obc_pkg::PH_HALT_EXIT: begin
				if (count_done) begin
					next_state = obc_pkg::PH_RUN;
				end
			end
			default: begin
				next_state = obc_pkg::PH_LOAD0;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state <= obc_pkg::PH_LOAD0;
		end else begin
			state <= next_state;
		end
	end

	// Capture byte 0 as it arrives from the store
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			load_byte0 <= obc_pkg::ERASED_BYTE;
		end else if (state == obc_pkg::PH_LOAD1) begin
			load_byte0 <= store_rd_data;
		end
	end

	// ==========================================================
	// Settings, latched once per reset
	assign next_settings = decode_bytes(load_byte0, store_rd_data);

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_settings <= decode_bytes(obc_pkg::ERASED_BYTE, obc_pkg::ERASED_BYTE); // RL13
		end else if (state == obc_pkg::PH_LOAD2) begin
			o_settings <= next_settings; // RL16
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_watchdog_hw_enable <= 1'b0;
			o_pll_select <= 1'b0;
			o_prescaler_halve <= 1'b0;
		end else if (state == obc_pkg::PH_LOAD2) begin
			o_watchdog_hw_enable <= ~next_settings.wdog_software_opt; // RL2
			o_pll_select <= ~next_settings.clock_source_opt; // RL3
			o_prescaler_halve <= ~next_settings.half_prescaler_opt; // RL9
		end
	end

	// ==========================================================
	// Reset phase and halt exit counter
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			count <= obc_pkg::RESET_CYCLES_LONG;
		end else if (state == obc_pkg::PH_LOAD2) begin
			count <= phase_cycles(next_settings); // RL6
		end else if (next_state == obc_pkg::PH_RESET_PHASE && state == obc_pkg::PH_RUN) begin
			count <= phase_cycles(o_settings); // RL7
		end else if (next_state == obc_pkg::PH_HALT_EXIT && state == obc_pkg::PH_HALT) begin
			count <= phase_cycles(o_settings); // RL6
		end else if ((state == obc_pkg::PH_RESET_PHASE || state == obc_pkg::PH_HALT_EXIT) && !count_done) begin
			count <= count - 13'h0001;
		end
	end

	// ==========================================================
	// CPU reset, halt and watchdog reset outputs
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_cpu_reset_n <= 1'b0;
		end else begin
			o_cpu_reset_n <= (next_state == obc_pkg::PH_RUN || next_state == obc_pkg::PH_HALT ||
				next_state == obc_pkg::PH_HALT_EXIT); // RL16
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_halted <= 1'b0;
		end else begin
			o_halted <= (next_state == obc_pkg::PH_HALT || next_state == obc_pkg::PH_HALT_EXIT);
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_wdog_halt_reset <= 1'b0;
		end else begin
			o_wdog_halt_reset <= (state == obc_pkg::PH_RUN) && i_halt_entry &&
				wdog_active && o_settings.wdog_halt_reset_opt; // RL1
		end
	end

	// ==========================================================
	// Motor outputs during the CPU reset phase, released while the load states run
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_motor_drive_level <= 1'b0;
			o_motor_drive_oe <= 1'b0;
		end else if (next_state == obc_pkg::PH_RESET_PHASE) begin
			case (next_settings.motor_output_reset_state & {2{state == obc_pkg::PH_LOAD2}} |
				o_settings.motor_output_reset_state & {2{state != obc_pkg::PH_LOAD2}})
				obc_pkg::MOTOR_LOW: begin
					o_motor_drive_level <= 1'b0; // RL15
					o_motor_drive_oe <= 1'b1;
				end
				obc_pkg::MOTOR_HIGH: begin
					o_motor_drive_level <= 1'b1; // RL15
					o_motor_drive_oe <= 1'b1;
				end
				default: begin
					o_motor_drive_level <= 1'b0; // RL15
					o_motor_drive_oe <= 1'b0;
				end
			endcase
		end else begin
			o_motor_drive_level <= 1'b0;
			o_motor_drive_oe <= 1'b0;
		end
	end

endmodule

// ### hw/obc_option_store.sv
// Purpose: Two byte non-volatile option store with registered read port
// Assumes: Power-on reset models the erased state of a fresh part
// Notes: Contents survive the system reset, only power-on or an option erase clears them
`timescale 1ns/1ps

module obc_option_store (
	// Clock and power-on reset
	input wire logic i_clk,
	input wire logic i_por_n,
	// Write and erase
	input wire logic i_wr,
	input wire logic i_wr_sel,
	input wire logic [7:0] i_wr_data,
	input wire logic i_erase,
	// Read port
	input wire logic i_rd_sel,
	output logic [7:0] o_rd_data,
	// Live contents
	output logic [7:0] o_byte0,
	output logic [7:0] o_byte1
);

	// ==========================================================
	// Storage, erased bytes read all ones
	always_ff @(posedge i_clk or negedge i_por_n) begin
		if (!i_por_n) begin
			o_byte0 <= obc_pkg::ERASED_BYTE; // RL13
			o_byte1 <= obc_pkg::ERASED_BYTE; // RL13
		end else if (i_erase) begin
			o_byte0 <= obc_pkg::ERASED_BYTE; // RL13
			o_byte1 <= obc_pkg::ERASED_BYTE; // RL13
		end else if (i_wr) begin
			if (i_wr_sel) begin
				o_byte1 <= i_wr_data;
			end else begin
				o_byte0 <= i_wr_data;
			end
		end
	end

	// ==========================================================
	// Registered read
	always_ff @(posedge i_clk or negedge i_por_n) begin
		if (!i_por_n) begin
			o_rd_data <= obc_pkg::ERASED_BYTE;
		end else begin
			o_rd_data <= i_rd_sel ? o_byte1 : o_byte0;
		end
	end

endmodule

// ### hw/obc_pkg.sv
// Purpose: Shared constants and types for the option byte configuration decoder
// Assumes: Single clock domain, option bytes held in a small local store
// Notes: Offsets address the programming port only, never the CPU map
package obc_pkg;

	// ==========================================================
	// Programming port offsets
	localparam logic [1:0] OFS_OPT0 = 2'h0;
	localparam logic [1:0] OFS_OPT1 = 2'h1;
	localparam logic [1:0] OFS_ERASE = 2'h2;
	localparam logic [1:0] OFS_STATUS = 2'h3;

	// ==========================================================
	// Option byte 0 field positions
	localparam int BIT_WDOG_HALT = 7;
	localparam int BIT_WDOG_SW = 6;
	localparam int BIT_CLK_SRC = 5;
	localparam int BIT_VD_HI = 4;
	localparam int BIT_VD_LO = 3;
	localparam int BIT_RST_LEN = 2;
	localparam int BIT_HALF_PRE = 1;
	localparam int BIT_RDP = 0;

	// Option byte 1 field positions
	localparam int BIT_MOTOR_HI = 1;
	localparam int BIT_MOTOR_LO = 0;

	// ==========================================================
	// Values after erase and reset
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [7:0] RD_DATA_RST = 8'h00;

	// ==========================================================
	// Voltage detect codes
	localparam logic [1:0] VD_BOTH_ON = 2'h0;
	localparam logic [1:0] VD_LOW_ONLY = 2'h1;
	localparam logic [1:0] VD_BOTH_OFF = 2'h2;
	localparam logic [1:0] VD_ERASED = 2'h3;

	// Motor output reset state codes
	localparam logic [1:0] MOTOR_HIZ_A = 2'h0;
	localparam logic [1:0] MOTOR_LOW = 2'h1;
	localparam logic [1:0] MOTOR_HIGH = 2'h2;
	localparam logic [1:0] MOTOR_HIZ_B = 2'h3;

	// ==========================================================
	// Reset phase and halt exit lengths in CPU cycles
	localparam logic [12:0] RESET_CYCLES_LONG = 13'h1000;
	localparam logic [12:0] RESET_CYCLES_SHORT = 13'h0100;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		PH_LOAD0,
		PH_LOAD1,
		PH_LOAD2,
		PH_RESET_PHASE,
		PH_RUN,
		PH_HALT,
		PH_HALT_EXIT
	} obc_state_t;

	typedef enum logic [1:0] {
		ER_IDLE,
		ER_USER_MEM,
		ER_OPTIONS
	} obc_erase_t;

	typedef struct packed {
		logic wdog_halt_reset_opt;
		logic wdog_software_opt;
		logic clock_source_opt;
		logic low_voltage_detector;
		logic aux_voltage_detector;
		logic reset_length_opt;
		logic half_prescaler_opt;
		logic readout_protect_opt;
		logic [1:0] motor_output_reset_state;
	} obc_settings_t;

endpackage

// ### testbench/obc_config_decoder_assertions.sv
// Purpose: Port checks for the option byte decoder
// Assumes: One clock, asynchronous active low reset
// Notes: Bound to every decoder instance
`timescale 1ns/1ps
module obc_config_decoder_assertions (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Watched inputs
	input wire logic i_prog_mode,
	input wire logic i_rd,
	input wire logic i_test_mode,
	input wire logic i_in_circuit_programming_mode,
	input wire logic i_halt_entry,
	// Watched outputs
	input wire logic [7:0] o_rd_data,
	input wire logic o_user_mem_block,
	input wire logic o_cpu_reset_n,
	input wire logic o_wdog_halt_reset,
	input wire obc_pkg::obc_settings_t o_settings,
	input wire logic o_watchdog_hw_enable,
	input wire logic o_pll_select,
	input wire logic o_prescaler_halve,
	input wire logic o_motor_drive_level,
	input wire logic o_motor_drive_oe
);
	// ==========================================================
	// Checks
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);

	a_wdog_type_map: assert property (o_watchdog_hw_enable == !o_settings.wdog_software_opt)
		else $error("watchdog enable differs from type bit");
	a_clock_src_map: assert property (o_pll_select == !o_settings.clock_source_opt)
		else $error("pll select differs from clock source bit");
	a_prescale_map: assert property (o_prescaler_halve == !o_settings.half_prescaler_opt)
		else $error("prescaler differs from divide bit");
	a_detect_order: assert property (o_settings.aux_voltage_detector |-> o_settings.low_voltage_detector)
		else $error("aux detector on without low detector");
	a_settings_hold: assert property (o_cpu_reset_n |-> $stable(o_settings))
		else $error("settings changed while running");
	a_motor_code: assert property (o_motor_drive_oe |->
		o_settings.motor_output_reset_state == {o_motor_drive_level, !o_motor_drive_level})
		else $error("motor drive does not match code");
	a_read_idle: assert property (!$past(i_rd && i_prog_mode) |-> o_rd_data == 8'h00)
		else $error("read data without accepted read");
	a_halt_pulse: assert property (o_wdog_halt_reset |->
		($past(i_halt_entry) && o_settings.wdog_halt_reset_opt && !o_cpu_reset_n) ##1 !o_wdog_halt_reset)
		else $error("halt reset pulse without cause");
	a_block_cause: assert property (o_user_mem_block |-> $past(i_test_mode || i_in_circuit_programming_mode))
		else $error("memory blocked outside test or in-circuit mode");
endmodule

bind obc_config_decoder obc_config_decoder_assertions u_chk (.i_clk, .i_resetn, .i_prog_mode, .i_rd,
	.i_test_mode, .i_in_circuit_programming_mode, .i_halt_entry, .o_rd_data, .o_user_mem_block,
	.o_cpu_reset_n, .o_wdog_halt_reset, .o_settings, .o_watchdog_hw_enable, .o_pll_select,
	.o_prescaler_halve, .o_motor_drive_level, .o_motor_drive_oe);

// ### testbench/obc_prog_tool.sv
// Purpose: Programming tool model for the option byte port
// Assumes: One access at a time, strobes one cycle long
// Notes: Released address and data lines show the inverse of their last value
`timescale 1ns/1ps
module obc_prog_tool (
	// Clock and read data
	input wire logic i_clk,
	input wire logic [7:0] i_rd_data,
	// Programming port
	output logic o_prog_mode,
	output logic [1:0] o_addr,
	output logic [7:0] o_wr_data,
	output logic o_wr,
	output logic o_rd
);
	initial begin
		o_prog_mode = 1'h1;
		o_addr = 2'h0;
		o_wr_data = 8'h00;
		o_wr = 1'h0;
		o_rd = 1'h0;
	end

	task automatic mode(input logic on);
		@(posedge i_clk);
		o_prog_mode <= on;
	endtask

	task automatic put(input logic [1:0] a, input logic [7:0] v);
		@(posedge i_clk);
		o_wr <= 1'h1;
		o_addr <= a;
		o_wr_data <= v;
		@(posedge i_clk);
		o_wr <= 1'h0;
		o_addr <= ~a;
		o_wr_data <= ~v;
	endtask

	task automatic get(input logic [1:0] a, output logic [7:0] v);
		@(posedge i_clk);
		o_rd <= 1'h1;
		o_addr <= a;
		@(posedge i_clk);
		o_rd <= 1'h0;
		o_addr <= ~a;
		#1 v = i_rd_data;
	endtask
endmodule

// ### testbench/option_byte_config_decoder_test.sv
// Purpose: Self-checking bench for the option byte decoder
// Assumes: 250 MHz clock, store survives system reset
// Notes: Rows load option bytes and check decode after reset
`timescale 1ns/1ps
module option_byte_config_decoder_test;
	typedef struct packed {
		logic [7:0] b0;
		logic [7:0] b1;
		logic [9:0] s;
		logic [15:0] n;
		logic oe;
		logic lvl;
	} obc_row_t;
	logic i_clk, i_resetn, i_por_n, i_prog_mode, i_wr, i_rd, i_test_mode, i_in_circuit_programming_mode;
	logic i_user_erase_done, i_wdog_sw_enabled, i_halt_entry, i_halt_wake;
	logic o_user_erase_req, o_user_mem_block, o_cpu_reset_n, o_halted, o_wdog_halt_reset;
	logic o_watchdog_hw_enable, o_pll_select, o_prescaler_halve, o_motor_drive_level, o_motor_drive_oe;
	logic [1:0] i_addr;
	logic [7:0] i_wr_data, o_rd_data, d;
	obc_pkg::obc_settings_t o_settings;
	int err_total, n_compared, halt_seen, cnt;
	obc_row_t rows [4] = '{
		'{8'hff, 8'hff, 10'h3ff, 16'h0100, 1'h0, 1'h0},
		'{8'hdf, 8'hfd, 10'h37d, 16'h1000, 1'h1, 1'h0},
		'{8'heb, 8'hfe, 10'h3ce, 16'h1000, 1'h1, 1'h1},
		'{8'h35, 8'hfc, 10'h094, 16'h0100, 1'h0, 1'h0}};

	obc_config_decoder dut (.i_clk, .i_resetn, .i_por_n, .i_prog_mode, .i_addr, .i_wr_data, .i_wr, .i_rd,
		.o_rd_data, .i_test_mode, .i_in_circuit_programming_mode, .i_user_erase_done, .o_user_erase_req,
		.o_user_mem_block, .i_wdog_sw_enabled, .i_halt_entry, .i_halt_wake, .o_cpu_reset_n, .o_halted,
		.o_wdog_halt_reset, .o_settings, .o_watchdog_hw_enable, .o_pll_select, .o_prescaler_halve,
		.o_motor_drive_level, .o_motor_drive_oe);
	obc_prog_tool tool (.i_clk(i_clk), .i_rd_data(o_rd_data), .o_prog_mode(i_prog_mode), .o_addr(i_addr),
		.o_wr_data(i_wr_data), .o_wr(i_wr), .o_rd(i_rd));

	initial begin
		i_clk = 1'h0;
		forever #2 i_clk = ~i_clk;
	end
	always @(posedge i_clk) if (o_wdog_halt_reset === 1'h1) halt_seen++;

	// ==========================================================
	// Helpers
	task automatic test_done();
		$display("compared %0d mismatched %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bail(input string what);
		err_total++;
		$display("[ERR] %s expected done seen timeout", what);
		test_done();
	endtask
	task automatic do_reset(input obc_row_t r);
		int c;
		i_resetn <= 1'h0;
		repeat (16) @(posedge i_clk);
		#1 chk("settings_in_reset", 16'h03ff, 16'(o_settings));
		@(posedge i_clk);
		i_resetn <= 1'h1;
		c = 0;
		while (o_cpu_reset_n !== 1'h1) begin
			@(posedge i_clk);
			#1 c++;
			if (c == 10) chk("motor", 16'({r.oe, r.oe & r.lvl}), 16'({o_motor_drive_oe, o_motor_drive_level}));
			if (c > 5000) bail("reset_release");
		end
		chk("reset_len", r.n + 16'h0003, 16'(c));
		chk("settings", 16'(r.s), 16'(o_settings));
		chk("decoded", 16'({~r.b0[6], ~r.b0[5], ~r.b0[1]}),
			16'({o_watchdog_hw_enable, o_pll_select, o_prescaler_halve}));
		$display("test reset %h %h done", r.b0, r.b1);
	endtask
	task automatic halt_in();
		@(posedge i_clk);
		i_halt_entry <= 1'h1;
		@(posedge i_clk);
		i_halt_entry <= 1'h0;
		repeat (2) @(posedge i_clk);
		#1;
	endtask
	task automatic wake_out(input int n);
		int c;
		@(posedge i_clk);
		i_halt_wake <= 1'h1;
		@(posedge i_clk);
		i_halt_wake <= 1'h0;
		c = 0;
		while (o_halted !== 1'h0) begin
			@(posedge i_clk);
			#1 c++;
			if (c > 5000) bail("halt_exit");
		end
		chk("halt_exit_len", 16'(n), 16'(c));
	endtask

	// ==========================================================
	// Sequence
	initial begin
		{i_resetn, i_por_n, i_test_mode, i_in_circuit_programming_mode} = 4'h0;
		{i_user_erase_done, i_wdog_sw_enabled, i_halt_entry, i_halt_wake} = 4'h0;
		repeat (4) @(posedge i_clk);
		i_por_n <= 1'h1;
		do_reset(rows[0]);
		foreach (rows[i]) begin
			tool.put(obc_pkg::OFS_OPT0, rows[i].b0);
			tool.put(obc_pkg::OFS_OPT1, rows[i].b1);
			do_reset(rows[i]);
		end
		halt_in();
		chk("halt_no_reset", 16'h0003, 16'({o_halted, o_cpu_reset_n}));
		wake_out(256);
		tool.mode(1'h0);
		tool.put(obc_pkg::OFS_OPT0, 8'h00);
		tool.get(obc_pkg::OFS_OPT0, d);
		chk("rd_no_prog", 16'h0000, 16'(d));
		tool.mode(1'h1);
		tool.get(obc_pkg::OFS_OPT0, d);
		chk("rd_opt0", 16'h0035, 16'(d));
		$display("test access done");
		tool.put(obc_pkg::OFS_OPT0, 8'hfe);
		for (int m = 0; m < 4; m++) begin
			@(posedge i_clk);
			{i_in_circuit_programming_mode, i_test_mode} <= 2'(m);
			repeat (2) @(posedge i_clk);
			#1 chk("mem_block", 16'(m != 0), 16'(o_user_mem_block));
		end
		tool.put(obc_pkg::OFS_OPT0, 8'hff);
		repeat (2) @(posedge i_clk);
		#1 chk("mem_open", 16'h0000, 16'(o_user_mem_block));
		@(posedge i_clk);
		{i_in_circuit_programming_mode, i_test_mode} <= 2'h0;
		$display("test protect done");
		tool.put(obc_pkg::OFS_OPT0, 8'hfe);
		tool.put(obc_pkg::OFS_ERASE, 8'h00);
		cnt = 0;
		while (o_user_erase_req !== 1'h1) begin
			@(posedge i_clk);
			#1 cnt++;
			if (cnt > 100) bail("erase_req");
		end
		tool.get(obc_pkg::OFS_STATUS, d);
		chk("status_busy", 16'h000f, 16'(d));
		tool.get(obc_pkg::OFS_OPT0, d);
		chk("opt0_before_wipe", 16'h00fe, 16'(d));
		@(posedge i_clk);
		i_user_erase_done <= 1'h1;
		@(posedge i_clk);
		i_user_erase_done <= 1'h0;
		repeat (3) @(posedge i_clk);
		#1 chk("erase_req_end", 16'h0000, 16'(o_user_erase_req));
		tool.get(obc_pkg::OFS_OPT0, d);
		chk("opt0_erased", 16'h00ff, 16'(d));
		tool.get(obc_pkg::OFS_OPT1, d);
		chk("opt1_erased", 16'h00ff, 16'(d));
		tool.put(obc_pkg::OFS_OPT1, 8'h00);
		tool.put(obc_pkg::OFS_ERASE, 8'h00);
		tool.get(obc_pkg::OFS_OPT1, d);
		chk("opt1_plain_erase", 16'h00ff, 16'({o_user_erase_req, d}));
		$display("test erase done");
		do_reset(rows[0]);
		halt_in();
		chk("halt_sw_off", 16'h0001, 16'({halt_seen != 0, o_halted}));
		wake_out(256);
		@(posedge i_clk);
		i_wdog_sw_enabled <= 1'h1;
		halt_in();
		chk("halt_sw_on", 16'h0002, 16'({halt_seen == 1, o_cpu_reset_n}));
		cnt = 0;
		while (o_cpu_reset_n !== 1'h1) begin
			@(posedge i_clk);
			#1 cnt++;
			if (cnt > 5000) bail("halt_reset_end");
		end
		$display("test halt done");
		test_done();
	end
endmodule
